/* File: common/tmgc_defines.svh */
// timing and encoding constants for the tape motion gap control block
`ifndef TMGC_DEFINES_SVH
`define TMGC_DEFINES_SVH
`define TMGC_CLK_MHZ        100
`define TMGC_SPEED_CHG_MS   300
`define TMGC_SS_RAMP_US     5000
`define TMGC_SS_HALF_US     2500
`define TMGC_ST_START_US    10000
`define TMGC_HOLD_RD_US     4000
`define TMGC_HOLD_WR_US     2800
`define TMGC_BACK_UNIT_US   1000
`define TMGC_RAMP_CYC       (`TMGC_SS_RAMP_US * `TMGC_CLK_MHZ)
`define TMGC_HALF_CYC       (`TMGC_SS_HALF_US * `TMGC_CLK_MHZ)
`define TMGC_GAP_SHORT      2'h0
`define TMGC_GAP_MID        2'h1
`define TMGC_GAP_LONG       2'h2
`endif

/* File: common/tmgc_pkg.sv */
// types shared by the tape motion gap control block
`default_nettype none
package tmgc_pkg;
	typedef enum logic [2:0]
	{
		st_stopped = 3'h0,
		st_run     = 3'h1,
		st_hold    = 3'h2,
		st_decel   = 3'h3,
		st_accel   = 3'h4,
		st_repo    = 3'h5,
		st_speed   = 3'h6
	} tmgc_state_type;
	typedef enum logic [2:0]
	{
		ph_stop = 3'h0,
		ph_ramp = 3'h1,
		ph_back = 3'h2,
		ph_brk  = 3'h3,
		ph_none = 3'h4
	} tmgc_phase_type;
endpackage
`default_nettype wire

/* File: verilog/tmgc_top.sv */
// tape motion sequencer: speed, holdover, gap length and reposition cycles
`include "tmgc_defines.svh"
`default_nettype none
// Function
// R1: speed change only after command finished
// R2: speed change takes about 300 ms
// R3: power-on speed from velocity switch
// R4: gap select by command, else switches
// R5: three maximum gap lengths per density
// R6: start/stop holdover before deceleration
// R7: reinstruct during decel reaccelerates without stopping
// R8: early write short gap, stopped long; code gives the short gap only when density_high, mid gap otherwise
// R9: low speed start/stop nominally 5 ms
// R10: restart immediately after full stop
// R11: streaming misses window, run reposition
// R12: capstan stops and backs tape
// R13: reposition: stop, ramp, back, stop
// R14: wait stopped, restart streaming 10 ms
// R15: streaming gap grows with reinstruct delay
// R16: first gap after reposition is short
// R17: buffered model keeps streaming
// R18: window measured from busy deassert
// R19: timer from completion chooses motion
module tmgc_top #(
	parameter int unsigned SPEED_CYC = `TMGC_SPEED_CHG_MS * 1000 * `TMGC_CLK_MHZ, // 300 ms
	parameter int unsigned START_CYC = `TMGC_ST_START_US * `TMGC_CLK_MHZ,        // 10 ms
	parameter int unsigned RAMP_CYC  = `TMGC_RAMP_CYC,                           // 5 ms ramp
	parameter int unsigned UNIT_CYC  = `TMGC_BACK_UNIT_US * `TMGC_CLK_MHZ,       // back unit
	parameter int unsigned HRD_CYC   = `TMGC_HOLD_RD_US * `TMGC_CLK_MHZ,         // read window
	parameter int unsigned HWR_CYC   = `TMGC_HOLD_WR_US * `TMGC_CLK_MHZ          // write window
) (
	input  wire logic       clk,          // 100 MHz clock
	input  wire logic       srst,         // synchronous reset, high
	input  wire logic       vel_switch,   // velocity switch: 1 = 100 ips
	input  wire logic [1:0] gap_switch,   // default maximum gap select
	input  wire logic       density_high, // 1 = group_coded_density 6250
	input  wire logic       buffered,     // buffered model, keep streaming
	input  wire logic       cmd_valid,    // new motion command pulse
	input  wire logic       cmd_write,    // command is a write
	input  wire logic       busy,         // busy output of the interface
	input  wire logic       speed_req,    // speed change command pulse
	input  wire logic       speed_val,    // requested speed: 1 = 100 ips
	input  wire logic       gap_req,      // gap select command pulse
	input  wire logic [1:0] gap_val,      // requested maximum gap
	output logic            speed_high,   // current speed 100 ips
	output logic [1:0]      gap_max,      // selected maximum gap
	output logic            motor_fwd,    // capstan forward drive
	output logic            motor_rev,    // capstan reverse drive
	output logic            ramping,      // capstan ramping
	output logic [1:0]      gap_code,     // gap length class produced
	output logic            gap_strobe,   // gap_code valid pulse
	output logic            speed_busy,   // speed change in progress
	output logic [1:0]      gap_scale     // streaming gap growth step
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tmgc_pkg::tmgc_state_type state, next_state;
	tmgc_pkg::tmgc_phase_type phase, next_phase;
	logic [31:0] timer, next_timer;
	logic        busy_d, next_busy_d;
	logic        init, next_init;
	logic        after_repo, next_after_repo;
	logic        last_write, next_last_write;
	logic        next_speed_high;
	logic [1:0]  next_gap_max, next_gap_code, next_gap_scale;
	logic        next_gap_strobe;
	logic [31:0] window;
	logic        done_edge;
	assign done_edge = busy_d && !busy; // R18
	// window for the current motion mode
	always_comb
	begin
		if (speed_high)
			window = UNIT_CYC * (32'h2 + {30'h0, gap_max});
		else
			window = last_write ? HWR_CYC : HRD_CYC; // R6
	end
	// next state of the sequencer
	always_comb
	begin
		next_state = state;
		next_phase = phase;
		next_timer = timer + 32'h1;
		next_busy_d = busy;
		next_init = 1'b0;
		next_after_repo = after_repo;
		next_last_write = last_write;
		next_speed_high = speed_high;
		next_gap_max = gap_max;
		next_gap_code = gap_code;
		next_gap_strobe = 1'b0;
		next_gap_scale = gap_scale;
		if (init)
		begin
			next_speed_high = vel_switch; // R3
			next_gap_max = gap_switch; // R4
		end
		if (gap_req && !busy && gap_val <= `TMGC_GAP_LONG)
			next_gap_max = gap_val; // R4 R5
		case (state)
			tmgc_pkg::st_stopped:
			begin
				if (speed_req && !busy && speed_val != speed_high)
				begin
					next_state = tmgc_pkg::st_speed; // R1
					next_timer = 32'h0;
				end
				else if (cmd_valid)
				begin
					next_state = tmgc_pkg::st_accel; // R10
					next_timer = 32'h0;
					next_last_write = cmd_write;
				end
			end
			tmgc_pkg::st_speed:
			begin
				if (timer >= SPEED_CYC - 1)
				begin
					next_state = tmgc_pkg::st_stopped; // R2
					next_speed_high = ~speed_high;
				end
			end
			tmgc_pkg::st_accel:
			begin
				if (timer >= (speed_high ? START_CYC : RAMP_CYC) - 1)
				begin
					next_state = tmgc_pkg::st_run; // R9 R14
					next_timer = 32'h0;
				end
			end
			tmgc_pkg::st_run:
			begin
				if (done_edge)
				begin
					next_state = tmgc_pkg::st_hold; // R19
					next_timer = 32'h0;
				end
			end
			tmgc_pkg::st_hold:
			begin
				if (cmd_valid)
				begin
					next_state = tmgc_pkg::st_run; // R11 R17
					next_last_write = cmd_write;
					next_gap_strobe = 1'b1;
					if (speed_high)
					begin
						next_gap_code = after_repo ? `TMGC_GAP_SHORT : `TMGC_GAP_MID; // R15 R16
						next_gap_scale = timer[31:1] < {1'b0, window[31:1]} ? 2'h1 : 2'h2;
						next_after_repo = 1'b0;
					end
					else
						next_gap_code = `TMGC_GAP_SHORT;
				end
				else if (timer >= window - 1 && !(buffered && speed_high))
				begin
					next_timer = 32'h0;
					next_state = speed_high ? tmgc_pkg::st_repo : tmgc_pkg::st_decel; // R11 R19
					next_phase = tmgc_pkg::ph_stop;
				end
			end
			tmgc_pkg::st_decel:
			begin
				if (cmd_valid)
				begin
					next_state = tmgc_pkg::st_accel; // R7
					next_timer = RAMP_CYC - timer; // shorter restart, R9
					next_last_write = cmd_write;
					next_gap_strobe = 1'b1;
					next_gap_code = (density_high && cmd_write && timer < RAMP_CYC / 2) ?
						`TMGC_GAP_SHORT : `TMGC_GAP_MID; // R8
				end
				else if (timer >= RAMP_CYC - 1)
				begin
					next_state = tmgc_pkg::st_stopped;
					next_gap_code = `TMGC_GAP_LONG; // R8
				end
			end
			tmgc_pkg::st_repo:
			begin
				// stop, ramp backward, run back by gap, brake R12 R13
				if (timer >= (phase == tmgc_pkg::ph_back ?
					UNIT_CYC * (32'h1 + {30'h0, gap_max}) : RAMP_CYC) - 1)
				begin
					next_timer = 32'h0;
					case (phase)
						tmgc_pkg::ph_stop: next_phase = tmgc_pkg::ph_ramp;
						tmgc_pkg::ph_ramp: next_phase = tmgc_pkg::ph_back;
						tmgc_pkg::ph_back: next_phase = tmgc_pkg::ph_brk;
						default:
						begin
							next_phase = tmgc_pkg::ph_none;
							next_state = tmgc_pkg::st_stopped; // R14
							next_after_repo = 1'b1;
						end
					endcase
				end
			end
			default: next_state = tmgc_pkg::st_stopped;
		endcase
		if (srst)
		begin
			next_state = tmgc_pkg::st_stopped;
			next_phase = tmgc_pkg::ph_none;
			next_timer = 32'h0;
			next_init = 1'b1;
			next_after_repo = 1'b1;
			next_last_write = 1'b0;
			next_gap_code = `TMGC_GAP_SHORT;
			next_gap_scale = 2'h0;
			next_busy_d = 1'b0;
		end
	end
	// register all state
	always_ff @(posedge clk)
	begin
		state <= next_state;
		phase <= next_phase;
		timer <= next_timer;
		busy_d <= next_busy_d;
		init <= next_init;
		after_repo <= next_after_repo;
		last_write <= next_last_write;
		speed_high <= next_speed_high;
		gap_max <= next_gap_max;
		gap_code <= next_gap_code;
		gap_strobe <= next_gap_strobe;
		gap_scale <= next_gap_scale;
	end
	// capstan drive decode
	assign motor_fwd = (state == tmgc_pkg::st_run) || (state == tmgc_pkg::st_hold)
		|| (state == tmgc_pkg::st_accel) || (state == tmgc_pkg::st_decel);
	assign motor_rev = (state == tmgc_pkg::st_repo) && (phase != tmgc_pkg::ph_stop); // R12
	assign ramping = (state == tmgc_pkg::st_accel) || (state == tmgc_pkg::st_decel);
	assign speed_busy = (state == tmgc_pkg::st_speed);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_speed_idle: assert property (@(posedge clk) disable iff (srst)
		(speed_req && (busy || (state != tmgc_pkg::st_stopped
		&& state != tmgc_pkg::st_speed))) |=> state != tmgc_pkg::st_speed)
		else $error("speed change taken while busy"); // R1
	a_decel_reaccel: assert property (@(posedge clk) disable iff (srst)
		(state == tmgc_pkg::st_decel && cmd_valid) |=> state == tmgc_pkg::st_accel)
		else $error("no reacceleration on reinstruct"); // R7
	a_repo_order: assert property (@(posedge clk) disable iff (srst)
		(phase == tmgc_pkg::ph_ramp && $past(phase) != tmgc_pkg::ph_ramp)
		|-> $past(phase) == tmgc_pkg::ph_stop)
		else $error("reposition phase order broken"); // R13
	a_repo_short: assert property (@(posedge clk) disable iff (srst)
		(state == tmgc_pkg::st_hold && cmd_valid && speed_high && after_repo)
		|=> gap_strobe && gap_code == `TMGC_GAP_SHORT)
		else $error("first gap after reposition not short"); // R16
	a_stop_restart: assert property (@(posedge clk) disable iff (srst || init)
		(state == tmgc_pkg::st_stopped && cmd_valid && !speed_req) |=> state == tmgc_pkg::st_accel)
		else $error("restart delayed after stop"); // R10
	a_hold_start: assert property (@(posedge clk) disable iff (srst)
		(state == tmgc_pkg::st_run && busy_d && !busy) |=> state == tmgc_pkg::st_hold && timer == 0)
		else $error("window not started at busy release"); // R18 R19
	a_rev_repo: assert property (@(posedge clk) disable iff (srst)
		motor_rev |-> state == tmgc_pkg::st_repo && !motor_fwd)
		else $error("reverse drive outside reposition"); // R12
	a_gap_range: assert property (@(posedge clk) disable iff (srst)
		gap_max != 2'h3)
		else $error("illegal maximum gap"); // R5
endmodule
`default_nettype wire

/* File: tb/tmgc_host_model.sv */
// host controller model issuing motion, speed and gap commands
`default_nettype none
module tmgc_host_model (
	input  wire logic  clk,       // system clock
	output logic       cmd_valid, // motion command pulse
	output logic       cmd_write, // command is a write
	output logic       busy,      // interface busy level
	output logic       speed_req, // speed change pulse
	output logic       speed_val, // requested speed
	output logic       gap_req,   // gap select pulse
	output logic [1:0] gap_val    // requested maximum gap
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial
	begin
		{cmd_valid, cmd_write, busy, speed_req, speed_val, gap_req} = 6'h00;
		gap_val = 2'h0;
	end
	// raise busy and pulse a command for one cycle
	task automatic issue(input logic wr);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		busy      = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask
	// command finishes: busy drops and the reinstruct window opens
	task automatic done(input int n);
		repeat (n) @(negedge clk);
		busy = 1'b0;
	endtask
	// speed change only once the previous command has finished
	task automatic set_speed(input logic v);
		@(negedge clk);
		speed_req = ~busy;
		speed_val = v;
		@(negedge clk);
		speed_req = 1'b0;
	endtask
	// gap select pulse
	task automatic set_gap(input logic [1:0] v);
		@(negedge clk);
		gap_req = 1'b1;
		gap_val = v;
		@(negedge clk);
		gap_req = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb/tmgc_top_tb_top.sv */
// self-checking testbench of the tape motion gap control block
`default_nettype none
module tmgc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, srst, vel_switch, cmd_valid, cmd_write, busy;
	logic       speed_req, speed_val, gap_req, speed_high, motor_fwd, motor_rev;
	logic       ramping, gap_strobe, speed_busy, density_high, buffered;
	logic [1:0] gap_switch, gap_val, gap_max, gap_code, gap_scale;
	int         mismatches, checks, cycles, rev_cycles;
	// design with short counts: ramp 20, start 30, unit 10, windows 40/28
	tmgc_top #(.SPEED_CYC(40), .START_CYC(30), .RAMP_CYC(20), .UNIT_CYC(10),
		.HRD_CYC(40), .HWR_CYC(28)) tmgc_top_inst (.clk(clk), .srst(srst),
		.vel_switch(vel_switch), .gap_switch(gap_switch), .density_high(density_high),
		.buffered(buffered), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .busy(busy),
		.speed_req(speed_req), .speed_val(speed_val), .gap_req(gap_req),
		.gap_val(gap_val), .speed_high(speed_high), .gap_max(gap_max),
		.motor_fwd(motor_fwd), .motor_rev(motor_rev), .ramping(ramping),
		.gap_code(gap_code), .gap_strobe(gap_strobe), .speed_busy(speed_busy),
		.gap_scale(gap_scale));
	tmgc_host_model tmgc_host_model_inst (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .busy(busy), .speed_req(speed_req),
		.speed_val(speed_val), .gap_req(gap_req), .gap_val(gap_val));
	// clock generation
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard and reverse drive monitor
	always @(posedge clk)
	begin
		cycles++;
		if (motor_rev === 1'b1)
			rev_cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			results();
		end
	end
	// compare two-bit results
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	// counts and verdict
	task automatic results();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// power on and mid-run reset take speed and gap from the switches
	task automatic t_power(input logic v, input logic [1:0] g);
		srst = 1'b1;
		vel_switch = v;
		gap_switch = g;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk({1'b0, speed_high}, {1'b0, v});
		chk(gap_max, g);
	endtask
	// every selectable gap, then an illegal code ignored
	task automatic t_gap();
		for (int v = 0; v < 4; v++)
		begin
			tmgc_host_model_inst.set_gap(v[1:0]);
			chk(gap_max, (v == 3) ? 2'h2 : v[1:0]);
		end
	endtask
	// start/stop: restart, holdover, early write reinstruct, full stop
	// first pass at group_coded_density, second at phase_coded_density
	task automatic t_start_stop();
		for (int d = 1; d >= 0; d--)
		begin
			density_high = d[0];
			tmgc_host_model_inst.issue(1'b1);
			chk({1'b0, ramping}, 2'h1);
			tmgc_host_model_inst.done(25);
			chk({motor_fwd, ramping}, 2'h2);
			repeat (33) @(negedge clk);
			chk({1'b0, ramping}, 2'h1);
			tmgc_host_model_inst.issue(1'b1);
			chk({1'b0, motor_fwd}, 2'h1);
			tmgc_host_model_inst.done(25);
			chk(gap_code, (d == 1) ? 2'h0 : 2'h1);
			repeat (60) @(negedge clk);
			chk({1'b0, motor_fwd}, 2'h0);
			chk(gap_code, 2'h2);
		end
	endtask
	// speed change to streaming
	task automatic t_speed();
		tmgc_host_model_inst.set_speed(1'b1);
		chk({1'b0, speed_busy}, 2'h1);
		repeat (45) @(negedge clk);
		chk({speed_busy, speed_high}, 2'h1);
	endtask
	// streaming: refused speed change, prompt reinstructs, reposition, restart
	task automatic t_stream();
		tmgc_host_model_inst.issue(1'b0);
		tmgc_host_model_inst.done(35);
		repeat (3) @(negedge clk);
		tmgc_host_model_inst.set_speed(1'b0);
		chk({speed_busy, speed_high}, 2'h1);
		tmgc_host_model_inst.issue(1'b0);
		chk({motor_fwd, motor_rev}, 2'h2);
		chk({1'b0, gap_strobe}, 2'h1);
		chk(gap_scale, 2'h1);
		tmgc_host_model_inst.done(35);
		repeat (5) @(negedge clk);
		tmgc_host_model_inst.issue(1'b0);
		chk(gap_code, 2'h1);
		tmgc_host_model_inst.done(35);
		repeat (250) @(negedge clk);
		chk({1'b0, rev_cycles != 0}, 2'h1);
		chk({motor_fwd, motor_rev}, 2'h0);
		tmgc_host_model_inst.issue(1'b0);
		tmgc_host_model_inst.done(35);
		repeat (3) @(negedge clk);
		tmgc_host_model_inst.issue(1'b0);
		chk({1'b0, gap_strobe}, 2'h1);
		repeat (2) @(negedge clk);
		chk(gap_code, 2'h0);
	endtask
	// buffered model at 100 ips keeps streaming past the window
	task automatic t_buffered();
		buffered = 1'b1;
		tmgc_host_model_inst.done(35);
		repeat (60) @(negedge clk);
		chk({motor_fwd, motor_rev}, 2'h2);
		tmgc_host_model_inst.issue(1'b0);
		chk(gap_code, 2'h1);
		chk(gap_scale, 2'h2);
		buffered = 1'b0;
	endtask
	// main sequence
	initial
	begin
		{mismatches, checks, cycles, rev_cycles} = '0;
		srst = 1'b1;
		vel_switch = 1'b0;
		gap_switch = 2'h2;
		density_high = 1'b1;
		buffered = 1'b0;
		t_power(1'b0, 2'h2);
		t_gap();
		t_start_stop();
		t_speed();
		t_stream();
		t_buffered();
		tmgc_host_model_inst.done(1);
		t_power(1'b0, 2'h1);
		t_power(1'b1, 2'h0);
		results();
	end
endmodule
`default_nettype wire
